//--- logic/peo_pkg.sv
// package: register map, field positions and widths for the port E / pin option block
package peo_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int E_W = 5;
    localparam int A_W = 8;
    localparam int C_W = 2;
    localparam int D_W = 6;
    // byte addresses; the option register sits at word index 0x1D, so four times that
    localparam logic [7:0] PIN_OPTION_CONTROL_IDX = 8'h1D;
    localparam logic [ADDR_W-1:0] ADDR_OPTION = 8'h74;
    localparam logic [ADDR_W-1:0] ADDR_E_DATA = 8'h20;
    localparam logic [ADDR_W-1:0] ADDR_E_DIR = 8'h24;
    localparam logic [ADDR_W-1:0] ADDR_USB_CTRL = 8'h28;
    localparam logic [ADDR_W-1:0] ADDR_DIR_AC = 8'h2C;
    // option register fields
    localparam int OPT_LOW_E_PU = 7;
    localparam int OPT_LED_SINK = 6;
    localparam int OPT_IR_SINK = 5;
    localparam int OPT_E4_PU = 4;
    localparam int OPT_E3_PU = 3;
    localparam int OPT_C_PU = 2;
    localparam int OPT_A_PU = 0;
    localparam logic [7:0] OPT_WMASK = 8'hFD;
    localparam logic [7:0] OPT_RESET = 8'h00;
    localparam logic [E_W-1:0] E_DIR_RESET = 5'h00;
    localparam logic [E_W-1:0] E_LATCH_RESET = 5'h00;
    localparam logic [A_W-1:0] A_DIR_RESET = 8'h00;
    localparam logic [C_W-1:0] C_DIR_RESET = 2'h0;
    // fields of the direction register for ports A and C
    localparam int DIR_A_LSB = 0;
    localparam int DIR_C_LSB = 8;
    localparam int USB_EN_BIT = 0;
    localparam int E4 = 4;
    localparam int E3 = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        PEO_W_IDLE = 2'b00,
        PEO_W_RESP = 2'b01
    } peo_wstate_t;
endpackage

//--- logic/peo_if.sv
// interface: register values passed from the bus slave to the pin logic
interface peo_regs_if;
    logic [7:0] option;
    logic [peo_pkg::E_W-1:0] e_dir;
    logic [peo_pkg::E_W-1:0] e_latch;
    logic [peo_pkg::A_W-1:0] a_dir;
    logic [peo_pkg::C_W-1:0] c_dir;
    logic usb_en;
    modport regs (output option, e_dir, e_latch, a_dir, c_dir, usb_en);
    modport pins (input option, e_dir, e_latch, a_dir, c_dir, usb_en);
endinterface

//--- logic/peo_pin_ctrl.sv
// pin control: buffers, pull-ups and sink-strength selects, all registered
module peo_pin_ctrl (
    input wire logic i_clock,
    input wire logic i_reset,
    peo_regs_if.pins regs,
    input wire logic [peo_pkg::D_W-1:0] i_d_dir,
    output logic [peo_pkg::E_W-1:0] o_e_out,
    output logic [peo_pkg::E_W-1:0] o_e_oe_n,
    output logic [peo_pkg::E_W-1:0] o_e_pullup,
    output logic [peo_pkg::A_W-1:0] o_a_pullup,
    output logic [peo_pkg::C_W-1:0] o_c_pullup,
    output logic [peo_pkg::D_W-1:0] o_d_high_sink,
    output logic o_usb_owns_e43
);
    logic [peo_pkg::E_W-1:0] e_gp_pu;
    logic [peo_pkg::E_W-1:0] usb_mask;

    always_comb begin
        usb_mask = '0;
        usb_mask[peo_pkg::E4] = regs.usb_en;
        usb_mask[peo_pkg::E3] = regs.usb_en;
        e_gp_pu = {peo_pkg::E_W{regs.option[peo_pkg::OPT_LOW_E_PU]}};
        e_gp_pu[peo_pkg::E4] = regs.option[peo_pkg::OPT_E4_PU] & ~regs.e_dir[peo_pkg::E4]
            & ~regs.usb_en;
        e_gp_pu[peo_pkg::E3] = regs.option[peo_pkg::OPT_E3_PU] & ~regs.e_dir[peo_pkg::E3]
            & ~regs.usb_en;
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_e_out <= '0;
            o_e_oe_n <= '1;
            o_e_pullup <= '0;
            o_usb_owns_e43 <= 1'b0;
        end else begin
            o_e_out <= regs.e_latch;
            // usb transceiver takes e4/e3, so the general buffer lets go
            o_e_oe_n <= ~(regs.e_dir & ~usb_mask);
            o_e_pullup <= e_gp_pu;
            o_usb_owns_e43 <= regs.usb_en;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_a_pullup <= '0;
            o_c_pullup <= '0;
        end else begin
            o_a_pullup <= {peo_pkg::A_W{regs.option[peo_pkg::OPT_A_PU]}}
                & ~regs.a_dir;
            o_c_pullup <= {peo_pkg::C_W{regs.option[peo_pkg::OPT_C_PU]}}
                & ~regs.c_dir;
        end
    end

    // high sink only acts on pins driven as outputs; otherwise standard open-drain
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_d_high_sink <= '0;
        end else begin
            o_d_high_sink[5:2] <= {4{regs.option[peo_pkg::OPT_LED_SINK]}}
                & i_d_dir[5:2];
            o_d_high_sink[1:0] <= {2{regs.option[peo_pkg::OPT_IR_SINK]}}
                & i_d_dir[1:0];
        end
    end
endmodule

//--- logic/peo_top.sv
// top: AXI4-Lite register slave for port E data/direction and the pin option register
module peo_top (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic [peo_pkg::ADDR_W-1:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [peo_pkg::DATA_W-1:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [peo_pkg::ADDR_W-1:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [peo_pkg::DATA_W-1:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    input wire logic [peo_pkg::E_W-1:0] i_e_pin,
    input wire logic [peo_pkg::D_W-1:0] i_d_dir,
    output logic [peo_pkg::E_W-1:0] o_e_out,
    output logic [peo_pkg::E_W-1:0] o_e_oe_n,
    output logic [peo_pkg::E_W-1:0] o_e_pullup,
    output logic [peo_pkg::A_W-1:0] o_a_pullup,
    output logic [peo_pkg::C_W-1:0] o_c_pullup,
    output logic [peo_pkg::D_W-1:0] o_d_high_sink,
    output logic o_usb_owns_e43
);
    peo_regs_if regs ();

    logic [7:0] option_q;
    logic [peo_pkg::E_W-1:0] e_direction_reg_q;
    logic [peo_pkg::E_W-1:0] e_data_latch_q;
    logic [peo_pkg::A_W-1:0] a_dir_q;
    logic [peo_pkg::C_W-1:0] c_dir_q;
    logic usb_module_enable_q;

    logic aw_held_q;
    logic [peo_pkg::ADDR_W-1:0] aw_addr_q;
    logic w_held_q;
    logic [peo_pkg::DATA_W-1:0] w_data_q;
    logic [3:0] w_strb_q;
    peo_pkg::peo_wstate_t wstate_q;
    logic do_write;
    logic wr_hit;
    logic [peo_pkg::DATA_W-1:0] rd_word;
    logic rd_hit;

    // write address and data accepted independently, in either order
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= '0;
            w_held_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= i_awaddr;
            end else if (do_write) begin
                aw_held_q <= 1'b0;
            end
            if (i_wvalid && o_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= i_wdata;
                w_strb_q <= i_wstrb;
            end else if (do_write) begin
                w_held_q <= 1'b0;
            end
        end
    end

    assign do_write = aw_held_q && w_held_q && (wstate_q == peo_pkg::PEO_W_IDLE);

    always_comb begin
        case (aw_addr_q)
            peo_pkg::ADDR_OPTION,
            peo_pkg::ADDR_E_DATA,
            peo_pkg::ADDR_E_DIR,
            peo_pkg::ADDR_USB_CTRL,
            peo_pkg::ADDR_DIR_AC: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            wstate_q <= peo_pkg::PEO_W_IDLE;
            o_bvalid <= 1'b0;
            o_bresp <= peo_pkg::RESP_OKAY;
            o_awready <= 1'b0;
            o_wready <= 1'b0;
        end else begin
            o_awready <= !aw_held_q && !(i_awvalid && o_awready);
            o_wready <= !w_held_q && !(i_wvalid && o_wready);
            case (wstate_q)
                peo_pkg::PEO_W_IDLE: begin
                    if (do_write) begin
                        wstate_q <= peo_pkg::PEO_W_RESP;
                        o_bvalid <= 1'b1;
                        o_bresp <= wr_hit ? peo_pkg::RESP_OKAY : peo_pkg::RESP_SLVERR;
                    end
                end
                peo_pkg::PEO_W_RESP: begin
                    if (i_bready) begin
                        wstate_q <= peo_pkg::PEO_W_IDLE;
                        o_bvalid <= 1'b0;
                    end
                end
                default: begin
                    wstate_q <= peo_pkg::PEO_W_IDLE;
                    o_bvalid <= 1'b0;
                end
            endcase
        end
    end

    // register stores; only byte lane 0 (and lane 1 for the A/C direction word) matter
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            option_q <= peo_pkg::OPT_RESET;
            e_direction_reg_q <= peo_pkg::E_DIR_RESET;
            e_data_latch_q <= peo_pkg::E_LATCH_RESET;
            a_dir_q <= peo_pkg::A_DIR_RESET;
            c_dir_q <= peo_pkg::C_DIR_RESET;
            usb_module_enable_q <= 1'b0;
        end else if (do_write) begin
            case (aw_addr_q)
                peo_pkg::ADDR_OPTION:
                    if (w_strb_q[0]) option_q <= w_data_q[7:0] & peo_pkg::OPT_WMASK;
                peo_pkg::ADDR_E_DATA:
                    // latch written whatever the direction bit holds
                    if (w_strb_q[0]) e_data_latch_q <= w_data_q[peo_pkg::E_W-1:0];
                peo_pkg::ADDR_E_DIR:
                    if (w_strb_q[0]) e_direction_reg_q <= w_data_q[peo_pkg::E_W-1:0];
                peo_pkg::ADDR_USB_CTRL:
                    if (w_strb_q[0]) usb_module_enable_q <= w_data_q[peo_pkg::USB_EN_BIT];
                peo_pkg::ADDR_DIR_AC: begin
                    if (w_strb_q[0]) a_dir_q <= w_data_q[peo_pkg::DIR_A_LSB +: peo_pkg::A_W];
                    if (w_strb_q[1]) c_dir_q <= w_data_q[peo_pkg::DIR_C_LSB +: peo_pkg::C_W];
                end
                default: ;
            endcase
        end
    end

    // read mux: per bit, latch for outputs, pin level for inputs
    always_comb begin
        rd_word = '0;
        rd_hit = 1'b1;
        case (i_araddr)
            peo_pkg::ADDR_OPTION: rd_word[7:0] = option_q;
            peo_pkg::ADDR_E_DATA:
                rd_word[peo_pkg::E_W-1:0] = (e_direction_reg_q & e_data_latch_q)
                    | (~e_direction_reg_q & i_e_pin);
            peo_pkg::ADDR_E_DIR: rd_word[peo_pkg::E_W-1:0] = e_direction_reg_q;
            peo_pkg::ADDR_USB_CTRL: rd_word[peo_pkg::USB_EN_BIT] = usb_module_enable_q;
            peo_pkg::ADDR_DIR_AC: begin
                rd_word[peo_pkg::DIR_A_LSB +: peo_pkg::A_W] = a_dir_q;
                rd_word[peo_pkg::DIR_C_LSB +: peo_pkg::C_W] = c_dir_q;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b0;
            o_rdata <= '0;
            o_rresp <= peo_pkg::RESP_OKAY;
        end else begin
            o_arready <= 1'b0;
            if (o_rvalid) begin
                if (i_rready) o_rvalid <= 1'b0;
            end else if (i_arvalid && !o_arready) begin
                // pin level sampled at acceptance; one read in flight at most
                o_arready <= 1'b1;
                o_rvalid <= 1'b1;
                o_rdata <= rd_word;
                o_rresp <= rd_hit ? peo_pkg::RESP_OKAY : peo_pkg::RESP_SLVERR;
            end
        end
    end

    assign regs.option = option_q;
    assign regs.e_dir = e_direction_reg_q;
    assign regs.e_latch = e_data_latch_q;
    assign regs.a_dir = a_dir_q;
    assign regs.c_dir = c_dir_q;
    assign regs.usb_en = usb_module_enable_q;

    peo_pin_ctrl u_pins (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .regs(regs),
        .i_d_dir(i_d_dir),
        .o_e_out(o_e_out),
        .o_e_oe_n(o_e_oe_n),
        .o_e_pullup(o_e_pullup),
        .o_a_pullup(o_a_pullup),
        .o_c_pullup(o_c_pullup),
        .o_d_high_sink(o_d_high_sink),
        .o_usb_owns_e43(o_usb_owns_e43)
    );
endmodule

//--- tb/peo_assertions.sv
// checker: bus answer timing and pin control relations at the top ports
module peo_assertions (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic o_rvalid,
    input wire logic i_rready,
    input wire logic [peo_pkg::DATA_W-1:0] o_rdata,
    input wire logic o_bvalid,
    input wire logic i_bready,
    input wire logic [1:0] o_bresp,
    input wire logic [peo_pkg::D_W-1:0] i_d_dir,
    input wire logic [peo_pkg::D_W-1:0] o_d_high_sink,
    input wire logic [peo_pkg::E_W-1:0] o_e_oe_n,
    input wire logic [peo_pkg::E_W-1:0] o_e_pullup,
    input wire logic o_usb_owns_e43
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_reset);
    sequence s_rd_req;
        i_arvalid && !o_rvalid && !o_arready;
    endsequence
    sequence s_rd_stall;
        o_rvalid && !i_rready;
    endsequence
    AST_RD_ANSWER: assert property (s_rd_req |=> o_arready && o_rvalid)
        else $error("read request not answered in one cycle");
    AST_RD_HOLD: assert property (s_rd_stall |=> o_rvalid && $stable(o_rdata))
        else $error("read data dropped before taken");
    AST_AR_PULSE: assert property (o_arready |=> !o_arready)
        else $error("read address ready longer than one cycle");
    AST_WR_HOLD: assert property (
        o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write response dropped before taken");
    AST_LOW_E_PU: assert property (
        o_e_pullup[0] == o_e_pullup[1] && o_e_pullup[1] == o_e_pullup[2])
        else $error("low port E pull-ups disagree");
    AST_SINK_DIR: assert property (
        (o_d_high_sink & ~$past(i_d_dir)) == 6'h00)
        else $error("high sink on a port D input");
    AST_E4_PU: assert property (
        o_e_pullup[4] |-> o_e_oe_n[4] && !o_usb_owns_e43)
        else $error("pin 4 pull-up while output or USB");
    AST_E3_PU: assert property (o_e_pullup[3] |-> o_e_oe_n[3] && !o_usb_owns_e43)
        else $error("pin 3 pull-up while output or USB");
    AST_USB_PINS: assert property (o_usb_owns_e43 |-> o_e_oe_n[4:3] == 2'h3)
        else $error("port E buffers on while USB owns pins");
    AST_RESET_OUT: assert property (
        $fell(i_reset) |-> o_e_oe_n == 5'h1F && o_e_pullup == 5'h00)
        else $error("pin outputs not at reset state");
endmodule

//--- tb/peo_pad_model.sv
// pad model: port E pins with outside driver, pull-ups and a floating level
module peo_pad_model (
    input wire logic i_clock,
    input wire logic [peo_pkg::E_W-1:0] i_out,
    input wire logic [peo_pkg::E_W-1:0] i_oe_n,
    input wire logic [peo_pkg::E_W-1:0] i_pullup,
    input wire logic [peo_pkg::E_W-1:0] i_ext,
    input wire logic i_ext_en,
    output logic [peo_pkg::E_W-1:0] o_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic float_q = 1'h0;
    logic [peo_pkg::E_W-1:0] idle_lvl;
    // floating pin toggles so a stale level never passes for a pull-up
    always @(posedge i_clock) float_q <= ~float_q;
    assign idle_lvl = i_ext_en ? i_ext : (i_pullup | {peo_pkg::E_W{float_q}});
    assign o_pin = (~i_oe_n & i_out) | (i_oe_n & idle_lvl);
endmodule

//--- tb/tb_top.sv
// testbench: register bus traffic, port E read-back and pin option checks
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clock = 1'h0;
    logic i_reset = 1'h1;
    logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
    logic i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h0, i_arvalid = 1'h0, i_rready = 1'h0;
    logic [31:0] i_wdata = 32'h0, o_rdata;
    logic [3:0] i_wstrb = 4'hF;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_usb_owns_e43, ext_en = 1'h1;
    logic [1:0] o_bresp, o_rresp, o_c_pullup;
    logic [4:0] i_e_pin, o_e_out, o_e_oe_n, o_e_pullup, ext = 5'h00;
    logic [5:0] i_d_dir = 6'h00, o_d_high_sink;
    logic [7:0] o_a_pullup;
    int miscompares = 0, num_checks = 0;
    always #25 i_clock = ~i_clock;
    peo_top DUT (.*);
    peo_pad_model pads (.i_clock(i_clock), .i_out(o_e_out), .i_oe_n(o_e_oe_n),
        .i_pullup(o_e_pullup), .i_ext(ext), .i_ext_en(ext_en), .o_pin(i_e_pin));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge i_clock);
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1'h1;
        i_wvalid <= 1'h1;
        i_bready <= 1'h1;
        do begin
            @(posedge i_clock);
            n++;
            if (o_awready) i_awvalid <= 1'h0;
            if (o_wready) i_wvalid <= 1'h0;
        end while (o_bvalid !== 1'h1 && n < 100);
        i_bready <= 1'h0;
        r = o_bresp;
        if (n >= 100) miscompares++;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge i_clock);
        i_araddr <= a;
        i_arvalid <= 1'h1;
        i_rready <= 1'h1;
        do begin
            @(posedge i_clock);
            n++;
            if (o_arready) i_arvalid <= 1'h0;
        end while (o_rvalid !== 1'h1 && n < 100);
        i_rready <= 1'h0;
        d = o_rdata;
        r = o_rresp;
        if (n >= 100) miscompares++;
    endtask
    function automatic logic [4:0] e_pu(logic [7:0] o, logic [4:0] dr, logic u);
        return {o[4] & ~dr[4] & ~u, o[3] & ~dr[3] & ~u, {3{o[7]}}};
    endfunction
    task give_verdict;
        if (miscompares == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge i_clock);
        miscompares++;
        give_verdict;
    end
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [4:0] dr, lat;
        logic [7:0] opt, adir;
        logic [1:0] cdir;
        logic u;
        logic [5:0] snk;
        void'($urandom(87164));
        repeat (8) @(posedge i_clock);
        i_reset <= 1'h0;
        rd(peo_pkg::ADDR_OPTION, d, r);
        chk("option reset", 32'h0, d);
        rd(peo_pkg::ADDR_E_DIR, d, r);
        chk("e dir reset", 32'h0, d);
        chk("e oe_n reset", 32'h1F, 32'(o_e_oe_n));
        wr(peo_pkg::ADDR_OPTION, 32'hFF, r);
        rd(peo_pkg::ADDR_OPTION, d, r);
        chk("option bit1", 32'hFD, d);
        i_wstrb <= 4'hE;
        wr(peo_pkg::ADDR_OPTION, 32'h00, r);
        i_wstrb <= 4'hF;
        rd(peo_pkg::ADDR_OPTION, d, r);
        chk("option lane0 off", 32'hFD, d);
        wr(8'h7C, 32'h1, r);
        chk("bad write resp", 32'(peo_pkg::RESP_SLVERR), 32'(r));
        rd(8'h7C, d, r);
        chk("bad read resp", {30'h0, peo_pkg::RESP_SLVERR}, {d[29:0], r});
        ext_en <= 1'h0;
        rd(peo_pkg::ADDR_E_DATA, d, r);
        chk("pulled pins", 32'h1F, d);
        ext_en <= 1'h1;
        for (int i = 0; i < 14; i++) begin
            dr = 5'($urandom);
            lat = 5'($urandom);
            opt = 8'($urandom);
            adir = 8'($urandom);
            cdir = 2'($urandom);
            u = (i == 0) ? 1'h1 : 1'($urandom);
            if (i == 0) dr = 5'h00;
            if (i == 0) opt = 8'h18;
            ext <= 5'($urandom);
            i_d_dir <= 6'($urandom);
            wr(peo_pkg::ADDR_E_DATA, 32'(lat), r);
            wr(peo_pkg::ADDR_E_DIR, 32'(dr), r);
            wr(peo_pkg::ADDR_USB_CTRL, 32'(u), r);
            wr(peo_pkg::ADDR_DIR_AC, {22'h0, cdir, adir}, r);
            wr(peo_pkg::ADDR_OPTION, 32'(opt), r);
            rd(peo_pkg::ADDR_E_DATA, d, r);
            chk("e data", 32'((dr & lat) | (~dr & ext)), d);
            chk("e data resp", 32'(peo_pkg::RESP_OKAY), 32'(r));
            chk("e pullups", 32'(e_pu(opt, dr, u)), 32'(o_e_pullup));
            chk("e oe_n", {27'h0, ~dr | {u, u, 3'h0}}, 32'(o_e_oe_n));
            chk("usb owns", 32'(u), 32'(o_usb_owns_e43));
            chk("e out", 32'(lat), 32'(o_e_out));
            chk("a pullups", {24'h0, opt[0] ? ~adir : 8'h00}, 32'(o_a_pullup));
            chk("c pullups", {30'h0, opt[2] ? ~cdir : 2'h0}, 32'(o_c_pullup));
            snk = {{4{opt[6]}}, {2{opt[5]}}} & i_d_dir;
            chk("sink", 32'(snk), 32'(o_d_high_sink));
        end
        give_verdict;
    end
endmodule
bind peo_top peo_assertions u_chk (.*);
